/* File: inc/dcbg_pkg.sv */
/*
 * dcbg_pkg: shared constants and types for the debug connect and boot gating
 * block, used by the device end, the probe end and the link interface.
 * Assumes a single 200 MHz clock for both ends.
 */
package dcbg_pkg;
    localparam int NCORE = 4;
    localparam int KEY_W = 256;
    localparam int WORD_W = 32;
    localparam int KEY_WORDS = 8;
    localparam int NKEY = 4;
    localparam int NSVR = 10;
    // key slots: 0 debug_access_key, 1 customer_key_a, 2 data_flash_key, 3 optional extra
    localparam logic [1:0] KEY_EXTRA = 2'h3;
    localparam logic [2:0] KEY_LAST_WORD = 3'h7;
    localparam logic [3:0] SVR_LAST = 4'h9;
    // asynchronous system pins seen by the device
    localparam int SI_EXT_RST = 0;
    localparam int SI_CYCLIC = 1;
    localparam int SI_STANDBY = 2;
    localparam int SI_SYS_RST = 3;
    localparam int SI_BOOT_SEL = 4;
    localparam int SI_USER_BOOT = 5;
    localparam int NSYNC = 6;
    // data bits of a debug start order
    localparam int ST_HOT_PLUG = 0;
    localparam int ST_INIT_STOP = 1;
    // trace lane counts
    localparam logic [2:0] LANES_ONE = 3'h1;
    localparam logic [2:0] LANES_TWO = 3'h2;
    localparam logic [2:0] LANES_FOUR = 3'h4;
    // probe register map (APB byte addresses)
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_DATA = 8'h04;
    localparam logic [7:0] A_STATUS = 8'h08;
    localparam logic [7:0] A_IRQ_STAT = 8'h0C;
    localparam logic [7:0] A_IRQ_MASK = 8'h10;
    localparam logic [7:0] A_CFG = 8'h14;
    localparam logic [7:0] A_KEY0 = 8'h20;
    localparam logic [7:0] A_KEY_END = 8'h3C;
    localparam int CTRL_GO = 3;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_FAIL = 1;
    localparam int IRQ_REFUSED = 2;
    localparam int NIRQ = 3;
    localparam int CFG_ATTACH = 0;
    localparam int CFG_ADAPTER = 1;
    localparam int CFG_LANES = 2;
    localparam int CFG_RAM_INIT = 5;
    localparam int CFG_W = 6;
    localparam int STAT_BUSY = 0;
    localparam int STAT_RESP = 1;
    localparam int STAT_LINK = 3;

    typedef logic [KEY_W-1:0] dcbg_key_t;
    typedef logic [WORD_W-1:0] dcbg_word_t;
    typedef enum logic [2:0] {
        OP_KEYSEL, OP_KEY, OP_SVR, OP_START, OP_STOP, OP_LANES, OP_RAMZERO, OP_DBGRST
    } dcbg_op_t;
    typedef enum logic [1:0] {RESP_OK, RESP_REFUSED, RESP_FAIL} dcbg_resp_t;
    typedef enum logic [1:0] {BOOT_NORMAL, BOOT_USER, BOOT_SERIAL} dcbg_boot_t;
endpackage

/* File: inc/dcbg_link_if.sv */
/*
 * dcbg_link_if: the debug link between probe end and device end.
 * Assumes both ends run on the same clock; req is held until ack.
 */
interface dcbg_link_if;
    logic req;
    dcbg_pkg::dcbg_op_t op;
    dcbg_pkg::dcbg_word_t wdata;
    logic ack;
    dcbg_pkg::dcbg_resp_t resp;
    logic link_rst;

    modport dev (input req, input op, input wdata, input link_rst, output ack, output resp);
    modport probe (output req, output op, output wdata, output link_rst, input ack, input resp);
endinterface

/* File: design/dcbg_device.sv */
/*
 * dcbg_device: device end of the debug link. Authenticates keys, gates debug
 * start, picks regulator settings, forces cores into break or init-stop hold on reset release while the probe is attached, selects
 * boot mode and flags reads of uninitialised RAM.
 * Assumes system pins are asynchronous and the link is on clk.
 */
// Design decisions made here: the three-stage pin sampling and the order responses.
module dcbg_device (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // debug link
    dcbg_link_if.dev lnk,
    // stored settings
    input wire dcbg_pkg::dcbg_key_t stored_key [dcbg_pkg::NKEY],
    input wire logic key_check_disable_bit,
    input wire dcbg_pkg::dcbg_word_t option_svr_word [dcbg_pkg::NSVR],
    // asynchronous system pins
    input wire logic [dcbg_pkg::NSYNC-1:0] sys_pins,
    // cores and RAM
    input wire logic [dcbg_pkg::NCORE-1:0] core_init_stopped,
    input wire logic ram_rd,
    input wire logic ram_rd_word_init,
    // outputs
    output logic session_active,
    output logic pins_to_debug,
    output logic serial_prog_en,
    output logic auth_fail,
    output logic extra_key_ok,
    output dcbg_pkg::dcbg_word_t svr_cfg [dcbg_pkg::NSVR],
    output logic [dcbg_pkg::NCORE-1:0] core_break,
    output logic [dcbg_pkg::NCORE-1:0] core_hold_stop,
    output dcbg_pkg::dcbg_boot_t boot_mode,
    output logic [2:0] trace_lanes,
    output logic ram_zero_fill,
    output logic ecc_err
);
    import dcbg_pkg::*;

    logic [NSYNC-1:0] s1_r, s2_r, s3_r, pin_r;
    logic sys_rst_d_r;
    logic pend_r, ack_r;
    dcbg_resp_t resp_r, resp_nxt;
    logic [1:0] key_sel_r;
    logic [2:0] key_cnt_r;
    dcbg_key_t key_buf_r, key_full;
    logic [NKEY-1:0] key_ok_r;
    logic auth_fail_r, session_r, started_r, init_stop_dbg_r, svr_use_r, ram_zeroed_r;
    logic ram_zero_fill_r, ecc_err_r, serial_prog_en_r, pins_to_debug_r;
    logic [3:0] svr_idx_r;
    dcbg_word_t svr_probe_r [NSVR];
    dcbg_word_t svr_cfg_r [NSVR];
    logic [NCORE-1:0] core_break_r, core_hold_r;
    dcbg_boot_t boot_r;
    logic [2:0] lanes_r;
    logic take, key_done, key_match, start_refused, rst_release, rst_assert;

    // three-stage pin sampling; a value counts once stages two and three agree
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            pin_r <= '0;
        end else begin
            s1_r <= sys_pins;
            s2_r <= s1_r;
            s3_r <= s2_r;
            pin_r <= (s2_r & s3_r) | (pin_r & (s2_r | s3_r));
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sys_rst_d_r <= 1'b0;
        end else begin
            sys_rst_d_r <= pin_r[SI_SYS_RST];
        end
    end

    assign rst_assert = pin_r[SI_SYS_RST] && !sys_rst_d_r;
    assign rst_release = !pin_r[SI_SYS_RST] && sys_rst_d_r;

    // one order per raised req; a new one needs req to drop first
    assign take = lnk.req && !pend_r;
    assign key_full = {key_buf_r[KEY_W-WORD_W-1:0], lnk.wdata};
    assign key_done = take && lnk.op == OP_KEY && key_cnt_r == KEY_LAST_WORD;
    assign key_match = key_full == stored_key[key_sel_r];

    always_comb begin
        start_refused = !(&key_ok_r[2:0]);
        if (!key_check_disable_bit) begin
            start_refused = 1'b1;
        end
        if (pin_r[SI_EXT_RST] || pin_r[SI_STANDBY] ||
            (lnk.wdata[ST_HOT_PLUG] && pin_r[SI_CYCLIC])) begin
            start_refused = 1'b1;
        end
    end

    always_comb begin
        resp_nxt = RESP_OK;
        unique case (lnk.op)
            OP_KEY: begin
                if (key_cnt_r == KEY_LAST_WORD && !key_match) begin
                    resp_nxt = RESP_FAIL;
                end
            end
            OP_SVR: begin
                if (started_r || svr_idx_r > SVR_LAST) begin
                    resp_nxt = RESP_REFUSED;
                end
            end
            OP_START: begin
                if (start_refused) begin
                    resp_nxt = RESP_REFUSED;
                end
            end
            OP_RAMZERO, OP_LANES: begin
                if (!session_r) begin
                    resp_nxt = RESP_REFUSED;
                end
            end
            OP_KEYSEL, OP_STOP, OP_DBGRST: resp_nxt = RESP_OK;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pend_r <= 1'b0;
            ack_r <= 1'b0;
            resp_r <= RESP_OK;
        end else begin
            ack_r <= take;
            if (take) begin
                pend_r <= 1'b1;
                resp_r <= resp_nxt;
            end else if (!lnk.req) begin
                pend_r <= 1'b0;
            end
        end
    end

    // key entry
    always_ff @(posedge clk) begin
        if (rst) begin
            key_sel_r <= 2'h0;
            key_cnt_r <= 3'h0;
            key_buf_r <= '0;
        end else if (take && lnk.op == OP_KEYSEL) begin
            key_sel_r <= lnk.wdata[1:0];
            key_cnt_r <= 3'h0;
        end else if (take && lnk.op == OP_KEY) begin
            key_buf_r <= key_full;
            key_cnt_r <= key_cnt_r + 3'h1;
        end
    end

    // extra keys are dropped on system reset assertion or a debug reset order; a same-cycle pass still sets
    always_ff @(posedge clk) begin
        if (rst) begin
            key_ok_r <= '0;
            auth_fail_r <= 1'b0;
        end else begin
            if (rst_assert || (take && lnk.op == OP_DBGRST)) begin
                key_ok_r[KEY_EXTRA] <= 1'b0;
            end
            if (key_done) begin
                key_ok_r[key_sel_r] <= key_match;
                auth_fail_r <= !key_match;
            end
        end
    end

    // session control
    always_ff @(posedge clk) begin
        if (rst) begin
            session_r <= 1'b0;
            started_r <= 1'b0;
            init_stop_dbg_r <= 1'b0;
        end else if (take && lnk.op == OP_START && !start_refused) begin
            session_r <= 1'b1;
            started_r <= 1'b1;
            init_stop_dbg_r <= lnk.wdata[ST_INIT_STOP];
        end else if ((take && lnk.op == OP_STOP) || !lnk.link_rst) begin
            session_r <= 1'b0;
        end
    end

    // probe regulator words; accepted and applied at once, only until the first start after power-up
    always_ff @(posedge clk) begin
        if (rst) begin
            svr_idx_r <= 4'h0;
            svr_use_r <= 1'b0;
            for (int i = 0; i < NSVR; i++) begin
                svr_probe_r[i] <= '0;
            end
        end else if (take && lnk.op == OP_SVR && resp_nxt == RESP_OK) begin
            svr_probe_r[svr_idx_r] <= lnk.wdata;
            svr_idx_r <= svr_idx_r + 4'h1;
            svr_use_r <= 1'b1;
        end
    end

    // option words are only read here, never written
    always_ff @(posedge clk) begin
        for (int i = 0; i < NSVR; i++) begin
            if (rst) begin
                svr_cfg_r[i] <= '0;
            end else begin
                svr_cfg_r[i] <= svr_use_r ? svr_probe_r[i] : option_svr_word[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            lanes_r <= LANES_ONE;
            ram_zeroed_r <= 1'b0;
            ram_zero_fill_r <= 1'b0;
        end else begin
            ram_zero_fill_r <= take && lnk.op == OP_RAMZERO && session_r;
            if (take && lnk.op == OP_LANES && session_r) begin
                lanes_r <= lnk.wdata[2:0];
            end
            if (take && lnk.op == OP_RAMZERO && session_r) begin
                ram_zeroed_r <= 1'b1;
            end
        end
    end

    // zero fill hides the error, as on real silicon it would not
    always_ff @(posedge clk) begin
        if (rst) begin
            ecc_err_r <= 1'b0;
        end else begin
            ecc_err_r <= ram_rd && !ram_rd_word_init && !ram_zeroed_r;
        end
    end

    // cores on reset release while the probe is attached
    always_ff @(posedge clk) begin
        if (rst) begin
            core_break_r <= '0;
            core_hold_r <= '0;
        end else if (!lnk.link_rst) begin
            core_break_r <= '0;
            core_hold_r <= '0;
        end else if (rst_release || (take && lnk.op == OP_DBGRST)) begin
            for (int i = 0; i < NCORE; i++) begin
                core_hold_r[i] <= init_stop_dbg_r && core_init_stopped[i];
                core_break_r[i] <= !(init_stop_dbg_r && core_init_stopped[i]);
            end
        end
    end

    // boot mode latched at each system reset release
    always_ff @(posedge clk) begin
        if (rst) begin
            boot_r <= BOOT_NORMAL;
        end else if (rst_release) begin
            if (pin_r[SI_BOOT_SEL] && !lnk.link_rst) begin
                boot_r <= BOOT_SERIAL;
            end else if (pin_r[SI_USER_BOOT]) begin
                boot_r <= BOOT_USER;
            end else begin
                boot_r <= BOOT_NORMAL;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            serial_prog_en_r <= 1'b0;
            pins_to_debug_r <= 1'b0;
        end else begin
            serial_prog_en_r <= boot_r == BOOT_SERIAL && !session_r;
            pins_to_debug_r <= session_r;
        end
    end

    assign lnk.ack = ack_r;
    assign lnk.resp = resp_r;
    assign session_active = session_r;
    assign pins_to_debug = pins_to_debug_r;
    assign serial_prog_en = serial_prog_en_r;
    assign auth_fail = auth_fail_r;
    assign extra_key_ok = key_ok_r[KEY_EXTRA];
    assign svr_cfg = svr_cfg_r;
    assign core_break = core_break_r;
    assign core_hold_stop = core_hold_r;
    assign boot_mode = boot_r;
    assign trace_lanes = lanes_r;
    assign ram_zero_fill = ram_zero_fill_r;
    assign ecc_err = ecc_err_r;
endmodule // dcbg_device

/* File: design/dcbg_probe.sv */
/*
 * dcbg_probe: probe end of the debug link, an APB slave for debugger
 * software. Sends keys top word first, clamps lane counts and chains the
 * RAM zero fill after a start. Assumes an APB master on clk.
 */
module dcbg_probe (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // APB slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    // debug link
    dcbg_link_if.probe lnk
);
    import dcbg_pkg::*;

    typedef enum {ST_IDLE, ST_REQ, ST_GAP} dcbg_pst_t;

    dcbg_pst_t st_r;
    logic pready_r, pslverr_r, irq_r, req_r, link_rst_r, go;
    logic [31:0] prdata_r, rd_nxt;
    dcbg_word_t data_r, wdata_r;
    dcbg_word_t key_mem [KEY_WORDS];
    logic [CFG_W-1:0] cfg_r;
    logic [NIRQ-1:0] irq_stat_r, irq_mask_r, irq_set;
    dcbg_op_t op_r;
    dcbg_resp_t resp_r;
    logic [2:0] kidx_r;
    logic wr, mapped;

    function automatic logic [2:0] legal_lanes(input logic adapter, input logic [2:0] n);
        legal_lanes = LANES_ONE;
        if (adapter && (n == LANES_TWO || n == LANES_FOUR)) begin
            legal_lanes = n;
        end
    endfunction

    // answer after one wait state; writes land on the edge that sees pready
    assign wr = psel && penable && pwrite && pready_r;
    assign go = wr && paddr == A_CTRL && pwdata[CTRL_GO] && st_r == ST_IDLE;
    assign mapped = paddr <= A_CFG || (paddr >= A_KEY0 && paddr <= A_KEY_END);

    always_comb begin
        rd_nxt = 32'h0;
        if (paddr >= A_KEY0 && paddr <= A_KEY_END) begin
            rd_nxt = key_mem[paddr[4:2]];
        end else if (paddr == A_CTRL) begin
            rd_nxt = {29'h0, op_r};
        end else if (paddr == A_DATA) begin
            rd_nxt = data_r;
        end else if (paddr == A_STATUS) begin
            rd_nxt = {28'h0, link_rst_r, resp_r, st_r != ST_IDLE};
        end else if (paddr == A_IRQ_STAT) begin
            rd_nxt = {29'h0, irq_stat_r};
        end else if (paddr == A_IRQ_MASK) begin
            rd_nxt = {29'h0, irq_mask_r};
        end else if (paddr == A_CFG) begin
            rd_nxt = {26'h0, cfg_r};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0;
        end else if (psel && penable && !pready_r) begin
            pready_r <= 1'b1;
            pslverr_r <= !mapped;
            prdata_r <= pwrite ? 32'h0 : rd_nxt;
        end else begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            data_r <= '0;
            cfg_r <= '0;
            irq_mask_r <= '0;
            for (int i = 0; i < KEY_WORDS; i++) begin
                key_mem[i] <= '0;
            end
        end else if (wr) begin
            if (paddr == A_DATA) begin
                data_r <= pwdata;
            end
            if (paddr == A_CFG) begin
                cfg_r <= pwdata[CFG_W-1:0];
            end
            if (paddr == A_IRQ_MASK) begin
                irq_mask_r <= pwdata[NIRQ-1:0];
            end
            if (paddr >= A_KEY0 && paddr <= A_KEY_END) begin
                key_mem[paddr[4:2]] <= pwdata;
            end
        end
    end

    // link sequencer; req drops for one cycle between chained orders
    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= ST_IDLE;
            req_r <= 1'b0;
            op_r <= OP_KEYSEL;
            wdata_r <= '0;
            kidx_r <= 3'h0;
            resp_r <= RESP_OK;
        end else begin
            unique case (st_r)
                ST_IDLE: begin
                    if (go) begin
                        op_r <= dcbg_op_t'(pwdata[2:0]);
                        req_r <= 1'b1;
                        st_r <= ST_REQ;
                        kidx_r <= KEY_LAST_WORD;
                        wdata_r <= data_r;
                        if (dcbg_op_t'(pwdata[2:0]) == OP_KEY) begin
                            wdata_r <= key_mem[KEY_LAST_WORD];
                        end
                        if (dcbg_op_t'(pwdata[2:0]) == OP_LANES) begin
                            wdata_r <= {29'h0, legal_lanes(cfg_r[CFG_ADAPTER], data_r[2:0])};
                        end
                    end
                end
                ST_REQ: begin
                    if (lnk.ack) begin
                        req_r <= 1'b0;
                        resp_r <= lnk.resp;
                        st_r <= ST_IDLE;
                        if (op_r == OP_KEY && kidx_r != 3'h0 && lnk.resp == RESP_OK) begin
                            kidx_r <= kidx_r - 3'h1;
                            wdata_r <= key_mem[kidx_r - 3'h1];
                            st_r <= ST_GAP;
                        end
                        if (op_r == OP_START && lnk.resp == RESP_OK && cfg_r[CFG_RAM_INIT]) begin
                            op_r <= OP_RAMZERO;
                            st_r <= ST_GAP;
                        end
                    end
                end
                ST_GAP: begin
                    req_r <= 1'b1;
                    st_r <= ST_REQ;
                end
            endcase
        end
    end

    always_comb begin
        irq_set = '0;
        if (st_r == ST_REQ && lnk.ack) begin
            irq_set[IRQ_FAIL] = lnk.resp == RESP_FAIL;
            irq_set[IRQ_REFUSED] = lnk.resp == RESP_REFUSED;
            irq_set[IRQ_DONE] = lnk.resp != RESP_OK ||
                !((op_r == OP_KEY && kidx_r != 3'h0) ||
                  (op_r == OP_START && cfg_r[CFG_RAM_INIT]));
        end
    end

    // set wins over a same-cycle write-one-to-clear
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_stat_r <= '0;
            irq_r <= 1'b0;
            link_rst_r <= 1'b0;
        end else begin
            if (wr && paddr == A_IRQ_STAT) begin
                irq_stat_r <= (irq_stat_r & ~pwdata[NIRQ-1:0]) | irq_set;
            end else begin
                irq_stat_r <= irq_stat_r | irq_set;
            end
            irq_r <= |(irq_stat_r & irq_mask_r);
            link_rst_r <= cfg_r[CFG_ATTACH];
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign irq = irq_r;
    assign lnk.req = req_r;
    assign lnk.op = op_r;
    assign lnk.wdata = wdata_r;
    assign lnk.link_rst = link_rst_r;
endmodule // dcbg_probe

/* File: tb/dcbg_link_asserts.sv */
/* dcbg_link_asserts: handshake checks on the debug link between the ends.
   assumes one clock and a synchronous active-high reset. */
module dcbg_link_asserts
    import dcbg_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // link signals
    input wire logic req,
    input wire dcbg_pkg::dcbg_op_t op,
    input wire dcbg_pkg::dcbg_word_t wdata,
    input wire logic ack,
    input wire dcbg_pkg::dcbg_resp_t resp,
    input wire logic link_rst
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_link_reset_idle: assert property ($fell(rst) |-> !req && !ack && resp == RESP_OK)
        else $error("link not idle after reset");
    a_ack_one_pulse: assert property (ack |=> !ack)
        else $error("ack longer than one cycle");
    a_ack_after_req: assert property ($rose(req) |=> ack)
        else $error("ack not one cycle after take");
    a_req_held: assert property (req && !ack |=> req)
        else $error("req dropped before ack");
    a_order_stable: assert property (req && !ack |=> $stable(op) && $stable(wdata))
        else $error("order changed while pending");
    a_req_gap: assert property (ack |=> !req)
        else $error("req not released after ack");
    a_resp_at_ack: assert property ($changed(resp) |-> ack)
        else $error("resp changed outside ack");
    a_fail_key_only: assert property (ack && resp == RESP_FAIL |-> op == OP_KEY)
        else $error("fail answer to a non-key order");
    c_start_ok: cover property (ack && resp == RESP_OK && op == OP_START);
    c_refused: cover property (ack && resp == RESP_REFUSED);
    c_key_fail: cover property (ack && resp == RESP_FAIL);
    c_detach: cover property ($fell(link_rst));
endmodule // dcbg_link_asserts

/* File: tb/debug_connect_boot_gating_tb_top.sv */
/* debug_connect_boot_gating_tb_top: both link ends joined, driven over APB.
   assumes a one-wait-state APB slave and a 4-edge pin sync in the device. */
module debug_connect_boot_gating_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import dcbg_pkg::*;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, ram_rd = 0, err;
    logic ram_rd_word_init = 0, extra_key_ok, ram_zero_fill;
    logic [2:0] trace_lanes;
    int n_fill = 0;
    logic key_check_disable_bit = 0, pready, pslverr, irq, session_active, pins_to_debug;
    logic serial_prog_en, auth_fail, ecc_err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [NSYNC-1:0] sys_pins = 6'h00;
    logic [NCORE-1:0] core_break, core_hold_stop;
    dcbg_key_t stored_key [NKEY];
    dcbg_word_t option_svr_word [NSVR], svr_cfg [NSVR];
    dcbg_boot_t boot_mode;
    int num_errors = 0, n_tests = 0;
    always #2.5 clk = ~clk;
    dcbg_link_if lnk();
    dcbg_device dcbg_device_inst (.clk, .rst, .lnk, .stored_key, .key_check_disable_bit,
        .option_svr_word, .sys_pins, .core_init_stopped(4'h5), .ram_rd, .ram_rd_word_init,
        .session_active, .pins_to_debug, .serial_prog_en, .auth_fail, .extra_key_ok,
        .svr_cfg, .core_break, .core_hold_stop, .boot_mode, .trace_lanes, .ram_zero_fill,
        .ecc_err);
    dcbg_probe dcbg_probe_inst (.clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .irq, .lnk);
    dcbg_link_asserts dcbg_link_asserts_inst (.clk, .rst, .req(lnk.req), .op(lnk.op),
        .wdata(lnk.wdata), .ack(lnk.ack), .resp(lnk.resp), .link_rst(lnk.link_rst));
    // the fill strobe is one cycle wide, so count it rather than sample it
    always @(posedge clk) begin
        if (ram_zero_fill === 1'b1) n_fill <= n_fill + 1;
    end
    task automatic end_of_test();
        if (num_errors == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    // values read right after the edge are the ones the edge sampled
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1;
        // no cycle count assumed; only the watchdog ends a hung wait
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic op(input dcbg_op_t o, input logic [31:0] d, input dcbg_resp_t e);
        apb(1, A_DATA, d);
        apb(1, A_CTRL, {28'h0, 1'b1, o});
        do begin
            apb(0, A_STATUS, 32'h0);
        end while (rd[STAT_BUSY] !== 1'b0);
        chk(rd[STAT_RESP+:2], e);
    endtask
    task automatic key(input logic [1:0] s, input dcbg_key_t k, input dcbg_resp_t e);
        op(OP_KEYSEL, s, RESP_OK);
        for (int i = 0; i < 8; i++) apb(1, A_KEY0 + 8'(4 * i), k[32*i+:32]);
        op(OP_KEY, 32'h0, e);
    endtask
    task automatic t_ecc(input logic w, input logic e);
        ram_rd_word_init <= w;
        ram_rd <= 1;
        @(posedge clk);
        ram_rd <= 0;
        @(posedge clk);
        chk(ecc_err, e);
    endtask
    task automatic t_refuse();
        op(OP_START, 32'h0, RESP_REFUSED);
        chk(session_active, 0);
        chk(irq, 0);
        apb(1, A_IRQ_MASK, 32'h4);
        wt(2);
        chk(irq, 1);
        apb(1, A_IRQ_STAT, 32'h7);
        wt(2);
        chk(irq, 0);
        apb(0, 8'hF0, 32'h0);
        chk({err, rd}, {1'b1, 32'h0});
    endtask
    task automatic t_badkey();
        key(2'h0, ~stored_key[0], RESP_FAIL);
        chk({auth_fail, session_active}, 2'b10);
    endtask
    task automatic t_start();
        for (int s = 0; s < 3; s++) key(2'(s), stored_key[s], RESP_OK);
        op(OP_START, 32'h0, RESP_REFUSED);
        key_check_disable_bit <= 1;
        // ext reset, cyclic with hot plug, standby
        for (int i = 0; i < 3; i++) begin
            sys_pins <= 6'h01 << i;
            wt(8);
            op(OP_START, 32'h1, RESP_REFUSED);
        end
        sys_pins <= 6'h00;
        wt(8);
        chk(svr_cfg[9], option_svr_word[9]);
        for (int i = 0; i < NSVR; i++) op(OP_SVR, 32'h5A5A0000 + i, RESP_OK);
        chk({svr_cfg[0], svr_cfg[9]}, {32'h5A5A0000, 32'h5A5A0009});
        apb(1, A_CFG, 32'h23);
        op(OP_START, 32'h2, RESP_OK);
        chk({session_active, pins_to_debug, serial_prog_en}, 3'b110);
        chk(n_fill, 1);
        t_ecc(1'b0, 1'b0);
        op(OP_LANES, 32'h4, RESP_OK);
        chk(trace_lanes, LANES_FOUR);
        apb(1, A_CFG, 32'h21);
        op(OP_LANES, 32'h4, RESP_OK);
        chk(trace_lanes, LANES_ONE);
        op(OP_SVR, 32'h0, RESP_REFUSED);
    endtask
    task automatic t_reset();
        key(2'h3, stored_key[3], RESP_OK);
        chk(extra_key_ok, 1);
        op(OP_DBGRST, 32'h0, RESP_OK);
        chk({extra_key_ok, core_break, core_hold_stop}, 9'h0A5);
        key(2'h3, stored_key[3], RESP_OK);
        sys_pins <= 6'h18;
        wt(8);
        sys_pins <= 6'h10;
        wt(8);
        chk({extra_key_ok, core_break, core_hold_stop}, 9'h0A5);
        chk(boot_mode, BOOT_NORMAL);
        op(OP_STOP, 32'h0, RESP_OK);
        chk({session_active, pins_to_debug}, 2'b00);
        apb(1, A_CFG, 32'h0);
        sys_pins <= 6'h18;
        wt(8);
        sys_pins <= 6'h10;
        wt(8);
        chk({boot_mode, serial_prog_en}, {BOOT_SERIAL, 1'b1});
    endtask
    initial begin
        for (int i = 0; i < NKEY; i++)
            for (int j = 0; j < 8; j++) stored_key[i][32*j+:32] = 32'h10000000 * (i + 1) + j;
        // settings-area words are fixed before reset release and never rewritten
        for (int i = 0; i < NSVR; i++) option_svr_word[i] = 32'hA0000000 + i;
        wt(4);
        rst <= 0;
        apb(1, A_CFG, 32'h1);
        t_ecc(1'b1, 1'b0);
        t_ecc(1'b0, 1'b1);
        t_refuse();
        t_badkey();
        t_start();
        t_reset();
        end_of_test();
    end
    initial begin
        #100000;
        num_errors++;
        end_of_test();
    end
endmodule // debug_connect_boot_gating_tb_top
